// ==== pmac_map.vh ====
// Command codes, field positions, reset values and counts of the
// power-converter management-bus slave. Assumes 7-bit bus addressing.
`ifndef PMAC_MAP_VH
`define PMAC_MAP_VH

// ----------------------------------------------------------------------
// Command codes
// ----------------------------------------------------------------------
`define PMAC_CMD_RUN        8'h01
`define PMAC_CMD_ONOFF      8'h02
`define PMAC_CMD_CLEAR      8'h03
`define PMAC_CMD_WLOCK      8'h10
`define PMAC_CMD_STORE_DEF  8'h11
`define PMAC_CMD_RESTO_DEF  8'h12
`define PMAC_CMD_STORE_USR  8'h15
`define PMAC_CMD_RESTO_USR  8'h16
`define PMAC_CMD_FEATURE    8'h19
`define PMAC_CMD_MASK       8'h1b
`define PMAC_CMD_FORMAT     8'h20
`define PMAC_CMD_SETPOINT   8'h21
`define PMAC_CMD_STATUS     8'h78
`define PMAC_CMD_VENDOR21   8'he5

// ----------------------------------------------------------------------
// Reset and fixed values
// ----------------------------------------------------------------------
`define PMAC_RST_RUN        8'h00
`define PMAC_RST_ONOFF      8'h16
`define PMAC_RST_WLOCK      8'h00
`define PMAC_VAL_FEATURE    8'hb0
`define PMAC_RST_MASK       8'h08
`define PMAC_VAL_FORMAT     8'h17
`define PMAC_RST_SETPOINT   16'h0133
`define PMAC_RST_VENDOR     8'h01

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PMAC_ONOFF_PU       4
`define PMAC_ONOFF_CMD      3
`define PMAC_ONOFF_CPR      2
`define PMAC_ONOFF_POL      1
`define PMAC_RUN_ON         7
`define PMAC_VENDOR_AUTO    0
`define PMAC_STAT_CML       1
`define PMAC_WLOCK_ALL      7
`define PMAC_WLOCK_RUN      6
`define PMAC_WLOCK_CFG      5

// ----------------------------------------------------------------------
// Bus constants and counts
// ----------------------------------------------------------------------
`define PMAC_ADDR_ALERT     7'h0c
`define PMAC_ADDR_BAD       7'h7f
`define PMAC_CRC_POLY       8'h07
`define PMAC_SOFT_CYCLES    128

`endif

// ==== pmac_top.v ====
// Management-bus slave of a power converter: bus, alert, enable, registers, ramp.
// Assumes SCL, SDA, straps, control pin and fault flags are asynchronous.
`timescale 1ns/1ps
`include "pmac_map.vh"

module pmac_top #(
  parameter SOFT_CYCLES = `PMAC_SOFT_CYCLES
) (
  // Clock and reset
  input  wire        i_sys_clk,
  input  wire        i_rst_n,
  // Management bus pins
  input  wire        i_scl,
  input  wire        i_sda,
  output reg         o_sda_out,
  output reg         o_sda_oe,
  output reg         o_alert_out,
  output reg         o_alert_oe,
  // Straps, control pin, fault flags
  input  wire [3:0]  i_address_strap_low,
  input  wire [3:0]  i_address_strap_high,
  input  wire        i_control_pin,
  input  wire [7:0]  i_fault_flags,
  // Power stage side
  input  wire        i_sw_cycle,
  output reg         o_regulation_enable,
  output reg  [15:0] o_setpoint,
  output reg  [7:0]  o_low_side_ramp,
  output reg         o_low_side_full
);

  localparam ST_IDLE = 3'd0;
  localparam ST_ADDR = 3'd1;
  localparam ST_WR   = 3'd2;
  localparam ST_RD   = 3'd3;
  localparam ST_IGN  = 3'd4;
  localparam [7:0] SOFT = SOFT_CYCLES[7:0];
  // ----------------------------------------------------------------------
  // Synchronisers
  // ----------------------------------------------------------------------
  // Sampling at 100 MHz gives over 100 samples per bus bit at 400 kHz
  reg [2:0] scl_s;
  reg [2:0] sda_s;
  // Faults [16:9], control pin [8], straps [7:0]; a strap change may skew for one cycle
  reg [16:0] in_s0, in_s1;

  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
      in_s0 <= 17'h00000;
      in_s1 <= 17'h00000;
    end else begin
      scl_s <= {scl_s[1:0], i_scl};
      sda_s <= {sda_s[1:0], i_sda};
      in_s0 <= {i_fault_flags, i_control_pin, i_address_strap_high, i_address_strap_low};
      in_s1 <= in_s0;
    end
  end
  wire scl_rise = scl_s[1] & ~scl_s[2];
  wire scl_fall = ~scl_s[1] & scl_s[2];
  wire sda_in   = sda_s[1];
  wire bus_start = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
  wire bus_stop  = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  reg [7:0]  run_cmd, onoff_cfg, wlock, mask, vendor_opt;
  reg [7:0]  nvm_onoff, nvm_wlock, nvm_mask;
  reg [15:0] nvm_setpoint;
  reg [7:0]  status, um_prev;
  reg        released;
  reg [6:0]  my_addr;

  // Out-of-range digit on either strap moves the slave to 127
  always @(posedge i_sys_clk) begin
    if (!i_rst_n)
      my_addr <= `PMAC_ADDR_BAD;
    else if (in_s1[3] | in_s1[7])
      my_addr <= `PMAC_ADDR_BAD;
    else
      my_addr <= {1'b0, in_s1[6:4], in_s1[2:0]};
  end
  // ----------------------------------------------------------------------
  // Bus engine
  // ----------------------------------------------------------------------
  reg [2:0]  state;
  reg [3:0]  bitcnt;
  reg [7:0]  shreg, tx, cmd, crc;
  reg [15:0] wd;
  reg [2:0]  nbytes;
  reg [1:0]  rd_idx;
  reg        rw, do_ack, is_ara, in_frame, wr_frame;
  reg        commit_p, bad_rd_p, ara_done;
  function [7:0] crc8;
    input [7:0] c;
    input [7:0] d;
    integer k;
    reg [7:0] r;
    begin
      r = c ^ d;
      for (k = 0; k < 8; k = k + 1)
        r = r[7] ? ({r[6:0], 1'b0} ^ `PMAC_CRC_POLY) : {r[6:0], 1'b0};
      crc8 = r;
    end
  endfunction
  wire [7:0] rx_byte = {shreg[6:0], sda_in};
  wire       rd_known = (cmd == `PMAC_CMD_RUN) || (cmd == `PMAC_CMD_ONOFF) ||
                        (cmd == `PMAC_CMD_WLOCK) || (cmd == `PMAC_CMD_FEATURE) ||
                        (cmd == `PMAC_CMD_MASK) || (cmd == `PMAC_CMD_FORMAT) ||
                        (cmd == `PMAC_CMD_SETPOINT) || (cmd == `PMAC_CMD_STATUS) ||
                        (cmd == `PMAC_CMD_VENDOR21);
  wire [1:0] rd_len = (cmd == `PMAC_CMD_SETPOINT) ? 2'd2 : 2'd1;
  reg  [7:0] rd_val;
  always @* begin
    case (cmd)
      `PMAC_CMD_RUN:      rd_val = run_cmd;
      `PMAC_CMD_ONOFF:    rd_val = onoff_cfg;
      `PMAC_CMD_WLOCK:    rd_val = wlock;
      `PMAC_CMD_FEATURE:  rd_val = `PMAC_VAL_FEATURE;
      `PMAC_CMD_MASK:     rd_val = mask;
      `PMAC_CMD_FORMAT:   rd_val = `PMAC_VAL_FORMAT;
      `PMAC_CMD_SETPOINT: rd_val = (rd_idx == 2'd0) ? o_setpoint[7:0] : o_setpoint[15:8];
      `PMAC_CMD_STATUS:   rd_val = status;
      `PMAC_CMD_VENDOR21: rd_val = vendor_opt;
      default:            rd_val = 8'hff;
    endcase
  end

  // Byte to send next: alert answer carries our address, then PEC
  wire [7:0] next_tx = is_ara ? ((rd_idx == 2'd0) ? {my_addr, 1'b0} : crc) :
                       (rd_idx < rd_len) ? rd_val :
                       (rd_idx == rd_len) ? crc : 8'hff;
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      state    <= ST_IDLE;
      bitcnt   <= 4'h0;
      crc      <= 8'h00;
      nbytes   <= 3'h0;
      rd_idx   <= 2'h0;
      in_frame <= 1'b0;
      wr_frame <= 1'b0;
      commit_p <= 1'b0;
      bad_rd_p <= 1'b0;
      ara_done <= 1'b0;
      o_sda_out <= 1'b0;
      o_sda_oe <= 1'b0;
    end else begin
      commit_p <= 1'b0;
      bad_rd_p <= 1'b0;
      ara_done <= 1'b0;
      if (bus_stop) begin
        // Write takes effect only at STOP, so PEC presence is known
        commit_p <= in_frame & wr_frame;
        state    <= ST_IDLE;
        in_frame <= 1'b0;
        wr_frame <= 1'b0;
        o_sda_oe <= 1'b0;
      end else if (bus_start) begin
        state    <= ST_ADDR;
        bitcnt   <= 4'h0;
        rd_idx   <= 2'h0;
        in_frame <= 1'b1;
        o_sda_oe <= 1'b0;
        if (!in_frame) begin
          crc    <= 8'h00;
          nbytes <= 3'h0;
        end
      end else if (scl_rise && state != ST_IDLE) begin
        shreg  <= rx_byte;
        bitcnt <= bitcnt + 4'h1;
        // Losing arbitration: we released but the line reads low
        if (state == ST_RD && bitcnt < 4'h8 && tx[3'h7 - bitcnt[2:0]] && !sda_in) begin
          state    <= ST_IGN;
          o_sda_oe <= 1'b0;
        end else if (state == ST_RD && bitcnt == 4'h8 && sda_in) begin
          state <= ST_IGN;
        end
        if (bitcnt == 4'h7) begin
          crc <= crc8(crc, rx_byte);
          case (state)
            ST_ADDR: begin
              rw <= rx_byte[0];
              // Alert address answered only while our alert line is low
              is_ara <= (rx_byte[7:1] == `PMAC_ADDR_ALERT) & rx_byte[0] & o_alert_oe;
              do_ack <= (rx_byte[7:1] == my_addr) |
                        ((rx_byte[7:1] == `PMAC_ADDR_ALERT) & rx_byte[0] & o_alert_oe);
              if (rx_byte[7:1] == my_addr)
                wr_frame <= ~rx_byte[0];
            end
            ST_WR: begin
              do_ack <= 1'b1;
              if (nbytes == 3'h0)
                cmd <= rx_byte;
              else if (nbytes == 3'h1)
                wd[7:0] <= rx_byte;
              else if (nbytes == 3'h2)
                wd[15:8] <= rx_byte;
              if (nbytes != 3'h7)
                nbytes <= nbytes + 3'h1;
            end
            ST_RD: begin
              if (is_ara && rd_idx == 2'h1 && !(tx[0] && !sda_in))
                ara_done <= 1'b1;
            end
            default: ;
          endcase
        end
      end else if (scl_fall && state != ST_IDLE) begin
        if (bitcnt == 4'h8) begin
          o_sda_oe <= (state == ST_ADDR || state == ST_WR) & do_ack;
        end else if (bitcnt == 4'h9) begin
          bitcnt   <= 4'h0;
          o_sda_oe <= 1'b0;
          if (state == ST_ADDR) begin
            if (!do_ack) begin
              state <= ST_IGN;
            end else if (rw) begin
              state    <= ST_RD;
              tx       <= next_tx;
              rd_idx   <= rd_idx + 2'h1;
              o_sda_oe <= ~next_tx[7];
              bad_rd_p <= ~is_ara & ~rd_known;
            end else begin
              state <= ST_WR;
            end
          end else if (state == ST_RD) begin
            tx       <= next_tx;
            if (rd_idx != 2'h3)
              rd_idx <= rd_idx + 2'h1;
            o_sda_oe <= ~next_tx[7];
          end
        end else if (state == ST_RD && bitcnt != 4'h0) begin
          o_sda_oe <= ~tx[3'h7 - bitcnt[2:0]];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Write decode at STOP
  // ----------------------------------------------------------------------
  reg [1:0] exp_len;
  reg       known;

  always @* begin
    known   = 1'b1;
    exp_len = 2'd1;
    case (cmd)
      `PMAC_CMD_CLEAR, `PMAC_CMD_STORE_DEF, `PMAC_CMD_RESTO_DEF,
      `PMAC_CMD_STORE_USR, `PMAC_CMD_RESTO_USR:
        exp_len = 2'd0;
      `PMAC_CMD_RUN, `PMAC_CMD_ONOFF, `PMAC_CMD_WLOCK, `PMAC_CMD_MASK,
      `PMAC_CMD_VENDOR21:
        exp_len = 2'd1;
      `PMAC_CMD_SETPOINT:
        exp_len = 2'd2;
      default:
        known = 1'b0;
    endcase
  end

  wire [2:0] data_cnt = nbytes - 3'h1;
  // Extra byte is PEC: good only if the running CRC came back to zero
  wire len_ok = (nbytes != 3'h0) && ((data_cnt == {1'b0, exp_len}) ||
                ((data_cnt == {1'b0, exp_len} + 3'h1) && (crc == 8'h00)));
  wire lock_ok = (cmd == `PMAC_CMD_WLOCK) ||
                 (!wlock[`PMAC_WLOCK_ALL] && !wlock[`PMAC_WLOCK_RUN] && !wlock[`PMAC_WLOCK_CFG]) ||
                 (!wlock[`PMAC_WLOCK_ALL] && !wlock[`PMAC_WLOCK_RUN] && cmd == `PMAC_CMD_RUN);
  wire wr_go  = commit_p & known & len_ok & lock_ok;
  wire cml_p  = (commit_p & ~(known & len_ok & lock_ok)) | bad_rd_p;
  wire clr_go = wr_go & (cmd == `PMAC_CMD_CLEAR);
  // ----------------------------------------------------------------------
  // Command registers and nonvolatile shadow
  // ----------------------------------------------------------------------
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      run_cmd      <= `PMAC_RST_RUN;
      onoff_cfg    <= `PMAC_RST_ONOFF;
      wlock        <= `PMAC_RST_WLOCK;
      mask         <= `PMAC_RST_MASK;
      vendor_opt   <= `PMAC_RST_VENDOR;
      o_setpoint   <= `PMAC_RST_SETPOINT;
      nvm_onoff    <= `PMAC_RST_ONOFF;
      nvm_wlock    <= `PMAC_RST_WLOCK;
      nvm_mask     <= `PMAC_RST_MASK;
      nvm_setpoint <= `PMAC_RST_SETPOINT;
    end else if (wr_go) begin
      case (cmd)
        `PMAC_CMD_RUN:      run_cmd    <= wd[7:0];
        `PMAC_CMD_ONOFF:    onoff_cfg  <= wd[7:0];
        `PMAC_CMD_WLOCK:    wlock      <= wd[7:0];
        `PMAC_CMD_MASK:     mask       <= wd[7:0];
        `PMAC_CMD_VENDOR21: vendor_opt <= wd[7:0];
        `PMAC_CMD_SETPOINT: o_setpoint <= wd;
        `PMAC_CMD_STORE_DEF, `PMAC_CMD_STORE_USR: begin
          nvm_onoff    <= onoff_cfg;
          nvm_wlock    <= wlock;
          nvm_mask     <= mask;
          nvm_setpoint <= o_setpoint;
        end
        `PMAC_CMD_RESTO_DEF, `PMAC_CMD_RESTO_USR: begin
          onoff_cfg  <= nvm_onoff;
          wlock      <= nvm_wlock;
          mask       <= nvm_mask;
          o_setpoint <= nvm_setpoint;
        end
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Status and alert line
  // ----------------------------------------------------------------------
  wire [7:0] cml_bit  = {6'h00, cml_p, 1'b0} << (`PMAC_STAT_CML - 1);
  // On clear, still-active faults and a fresh error set again at once
  wire [7:0] next_status = clr_go ? (in_s1[16:9] | cml_bit) :
                           (status | in_s1[16:9] | cml_bit);
  wire [7:0] unmasked = status & ~mask;
  wire       new_bits = |(unmasked & ~um_prev);
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      status      <= 8'h00;
      um_prev     <= 8'h00;
      released    <= 1'b0;
      o_alert_out <= 1'b0;
      o_alert_oe  <= 1'b0;
    end else begin
      status  <= next_status;
      um_prev <= unmasked;
      // A newly set bit wins over a release in the same cycle
      if (new_bits || clr_go)
        released <= 1'b0;
      else if (ara_done && vendor_opt[`PMAC_VENDOR_AUTO])
        released <= 1'b1;
      // Standard mode holds the line until the unmasked bits are cleared or masked
      o_alert_oe <= |unmasked & ~(released & ~new_bits);
    end
  end

  // ----------------------------------------------------------------------
  // Enable source and low-side ramp
  // ----------------------------------------------------------------------
  wire pin_ok = onoff_cfg[`PMAC_ONOFF_POL] ? in_s1[8] : ~in_s1[8];
  wire run_ok = ~onoff_cfg[`PMAC_ONOFF_PU] |
                ((~onoff_cfg[`PMAC_ONOFF_CMD] | run_cmd[`PMAC_RUN_ON]) &
                 (~onoff_cfg[`PMAC_ONOFF_CPR] | pin_ok));
  reg [7:0] ramp;
  always @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      o_regulation_enable <= 1'b0;
      ramp                <= 8'h00;
      o_low_side_ramp     <= 8'h00;
      o_low_side_full     <= 1'b0;
    end else begin
      o_regulation_enable <= run_ok;
      // Ramp restarts whenever regulation stops, to protect a pre-biased output
      if (!o_regulation_enable)
        ramp <= 8'h00;
      else if (i_sw_cycle && ramp != SOFT)
        ramp <= ramp + 8'h01;
      o_low_side_ramp <= ramp;
      o_low_side_full <= (ramp == SOFT);
    end
  end

endmodule

// ==== pmac_host.sv ====
// Host model of the management bus: START, STOP and nine-clock byte tasks.
// Assumes the bench wires SDA as open drain with a pull-up.
`timescale 1ns/1ps
module pmac_host (
  // Bus lines
  output logic o_scl,
  output logic o_sda_drv,
  input  wire  i_sda
);
  // Quarter of a 160 ns bus period; data moves mid-low so it never fakes a START
  localparam time Q = 40;
  initial begin
    o_scl     = 1'b1;
    o_sda_drv = 1'b1;
  end
  task automatic bstart();
    #Q o_sda_drv = 1'b1;
    #Q o_scl = 1'b1;
    #Q o_sda_drv = 1'b0;
    #Q o_scl = 1'b0;
  endtask
  task automatic bstop();
    #Q o_sda_drv = 1'b0;
    #Q o_scl = 1'b1;
    #Q o_sda_drv = 1'b1;
    #Q;
  endtask
  // Ninth bit: host ack level on reads, released on writes
  task automatic byte_io(input logic [7:0] d, input logic last, output logic [7:0] q, output logic ack);
    logic [8:0] w;
    logic [8:0] r;
    w = {d, last};
    for (int i = 8; i >= 0; i--) begin
      #Q o_sda_drv = w[i];
      #Q o_scl = 1'b1;
      #Q r[i] = i_sda;
      #Q o_scl = 1'b0;
    end
    q = r[8:1];
    ack = r[0];
  endtask
endmodule

// ==== pmac_top_chk.sv ====
// Pin-level assertions for the management-bus slave.
// Assumes one clock domain; bound into the top module below.
`timescale 1ns/1ps
module pmac_top_chk #(
  parameter SOFT_CYCLES = 128
) (
  // Clock and reset
  input wire        i_sys_clk,
  input wire        i_rst_n,
  // Bus and alert
  input wire        i_scl,
  input wire        i_sda,
  input wire        o_sda_out,
  input wire        o_sda_oe,
  input wire        o_alert_out,
  input wire        o_alert_oe,
  // Straps and control
  input wire [3:0]  i_address_strap_low,
  input wire [3:0]  i_address_strap_high,
  input wire        i_control_pin,
  input wire [7:0]  i_fault_flags,
  // Power stage
  input wire        i_sw_cycle,
  input wire        o_regulation_enable,
  input wire [15:0] o_setpoint,
  input wire [7:0]  o_low_side_ramp,
  input wire        o_low_side_full
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  a_alert_out_low: assert property (o_alert_out == 1'b0) else $error("alert data not low");
  a_sda_out_low: assert property (o_sda_out == 1'b0) else $error("sda data not low");
  a_alert_on_fault: assert property ($rose(i_fault_flags[0]) |-> ##[1:8] o_alert_oe)
    else $error("fault did not pull alert");
  a_sda_moves_low: assert property ($changed(o_sda_oe) |-> !$past(i_scl, 2))
    else $error("sda drive changed with clock high");
  a_setpoint_at_stop: assert property ($changed(o_setpoint) |-> $past(i_scl, 2) && $past(i_scl, 5))
    else $error("setpoint changed inside a frame");
  a_ramp_one_step: assert property (o_low_side_ramp != 8'h00 && $changed(o_low_side_ramp)
    |-> o_low_side_ramp == $past(o_low_side_ramp) + 8'h01) else $error("ramp jumped");
  a_ramp_limit: assert property (o_low_side_ramp <= SOFT_CYCLES) else $error("ramp past limit");
  a_ramp_idle: assert property (!o_regulation_enable [*3] |-> o_low_side_ramp == 8'h00)
    else $error("ramp counts while off");
  a_full_at_count: assert property (o_low_side_full |-> o_low_side_ramp == SOFT_CYCLES)
    else $error("full without full count");
endmodule
bind pmac_top pmac_top_chk #(.SOFT_CYCLES(SOFT_CYCLES)) u_chk (
  .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_scl(i_scl), .i_sda(i_sda), .o_sda_out(o_sda_out),
  .o_sda_oe(o_sda_oe), .o_alert_out(o_alert_out), .o_alert_oe(o_alert_oe),
  .i_address_strap_low(i_address_strap_low), .i_address_strap_high(i_address_strap_high),
  .i_control_pin(i_control_pin), .i_fault_flags(i_fault_flags), .i_sw_cycle(i_sw_cycle),
  .o_regulation_enable(o_regulation_enable), .o_setpoint(o_setpoint), .o_low_side_ramp(o_low_side_ramp),
  .o_low_side_full(o_low_side_full));

// ==== pmac_top_bench.sv ====
// Self-checking bench for the management-bus slave with a host model.
// Assumes the host model and the checker are compiled first.
`timescale 1ns/1ps
`include "pmac_map.vh"
module pmac_top_bench;
  localparam int SC = 8;
  localparam logic [7:0] RC [7] = '{8'h01, 8'h02, 8'h10, 8'h19, 8'h1b, 8'h20, 8'h99};
  localparam logic [7:0] RV [7] = '{8'h00, 8'h16, 8'h00, 8'hb0, 8'h08, 8'h17, 8'hff};
  localparam logic [7:0] CF [4] = '{8'h16, 8'h14, 8'h1a, 8'h1e};
  logic        i_sys_clk;
  logic        i_rst_n;
  logic        pin;
  logic        sw;
  logic [3:0]  st_lo;
  logic [3:0]  st_hi;
  logic [7:0]  faults;
  logic [6:0]  addr;
  logic [7:0]  run;
  logic [7:0]  q;
  logic        a;
  logic [15:0] v;
  logic [15:0] sv;
  wire         scl;
  wire         sda_drv;
  wire         sda_oe;
  wire         alert_oe;
  wire         en;
  wire         full;
  wire  [15:0] setpoint;
  wire  [7:0]  ramp;
  // Open-drain wire with pull-up
  wire         sda = sda_drv & ~sda_oe;
  int          error_cnt;
  int          comparisons;
  pmac_top #(.SOFT_CYCLES(SC)) u_pmac_top (
    .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_scl(scl), .i_sda(sda), .o_sda_out(), .o_sda_oe(sda_oe),
    .o_alert_out(), .o_alert_oe(alert_oe), .i_address_strap_low(st_lo), .i_address_strap_high(st_hi),
    .i_control_pin(pin), .i_fault_flags(faults), .i_sw_cycle(sw), .o_regulation_enable(en),
    .o_setpoint(setpoint), .o_low_side_ramp(ramp), .o_low_side_full(full));
  pmac_host u_pmac_host (.o_scl(scl), .o_sda_drv(sda_drv), .i_sda(sda));
  initial begin
    i_sys_clk = 1'b0;
    forever #5 i_sys_clk = ~i_sys_clk;
  end
  task automatic give_verdict();
    $display("Comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic check(string w, logic [15:0] e, logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic chkb(string w, logic e, logic g);
    check(w, {15'h0000, e}, {15'h0000, g});
  endtask
  function automatic logic [7:0] crc8(logic [7:0] c, logic [7:0] d);
    logic [7:0] x;
    x = c ^ d;
    for (int i = 0; i < 8; i++) x = x[7] ? {x[6:0], 1'b0} ^ `PMAC_CRC_POLY : {x[6:0], 1'b0};
    return x;
  endfunction
  function automatic logic exp_en(logic [7:0] cfg, logic [7:0] r, logic p);
    return !cfg[4] | ((!cfg[3] | r[7]) & (!cfg[2] | (p ^ !cfg[1])));
  endfunction
  task automatic idle(int n);
    repeat (n) @(negedge i_sys_clk);
  endtask
  // Write n data bytes low first; pec 0 none, 1 good, 2 corrupted
  task automatic wr(logic [7:0] cmd, int n, logic [15:0] d, int pec);
    logic [7:0] c;
    c = crc8(crc8(8'h00, {addr, 1'b0}), cmd);
    u_pmac_host.bstart();
    u_pmac_host.byte_io({addr, 1'b0}, 1'b1, q, a);
    u_pmac_host.byte_io(cmd, 1'b1, q, a);
    for (int i = 0; i < n; i++) begin
      u_pmac_host.byte_io(d[8*i+:8], 1'b1, q, a);
      c = crc8(c, d[8*i+:8]);
    end
    if (pec > 0) u_pmac_host.byte_io(pec == 1 ? c : ~c, 1'b1, q, a);
    u_pmac_host.bstop();
    idle(8);
  endtask
  task automatic rd(logic [7:0] cmd, int n, output logic [15:0] r);
    r = 16'h0000;
    u_pmac_host.bstart();
    u_pmac_host.byte_io({addr, 1'b0}, 1'b1, q, a);
    u_pmac_host.byte_io(cmd, 1'b1, q, a);
    u_pmac_host.bstart();
    u_pmac_host.byte_io({addr, 1'b1}, 1'b1, q, a);
    chkb("read address ack", 1'b0, a);
    for (int i = 0; i < n; i++) begin
      u_pmac_host.byte_io(8'hff, i == n - 1, q, a);
      r[8*i+:8] = q;
    end
    u_pmac_host.bstop();
  endtask
  // Modified receive byte at the alert address; host ends it with NACK
  task automatic ara(output logic [7:0] r, output logic k);
    u_pmac_host.bstart();
    u_pmac_host.byte_io({`PMAC_ADDR_ALERT, 1'b1}, 1'b1, q, k);
    u_pmac_host.byte_io(8'hff, 1'b1, r, a);
    u_pmac_host.bstop();
    idle(8);
  endtask
  initial begin
    repeat (100000) @(posedge i_sys_clk);
    error_cnt++;
    give_verdict();
  end
  initial begin
    error_cnt = 0;
    comparisons = 0;
    void'($urandom(78));
    {i_rst_n, pin, sw, faults} = '0;
    st_lo = 4'($urandom_range(7));
    st_hi = 4'($urandom_range(7, 2));
    addr = {1'b0, st_hi[2:0], st_lo[2:0]};
    idle(20);
    i_rst_n = 1'b1;
    idle(8);
    foreach (RC[i]) begin
      rd(RC[i], 1, v);
      check("reset value", {8'h00, RV[i]}, v);
    end
    rd(8'h21, 2, v);
    check("setpoint reset", 16'h0133, v);
    wr(8'h03, 0, 16'h0000, 0);
    $display("Test reset values done");
    foreach (CF[k]) begin
      wr(8'h02, 1, {8'h00, CF[k]}, 0);
      repeat (3) begin
        run = $urandom_range(1) ? 8'h80 : 8'h00;
        wr(8'h01, 1, {8'h00, run}, 0);
        @(negedge i_sys_clk) pin = 1'($urandom_range(1));
        idle(8);
        chkb("enable", exp_en(CF[k], run, pin), en);
      end
    end
    $display("Test enable sources done");
    pin = 1'b0;
    idle(8);
    check("ramp off", 16'h0000, {8'h00, ramp});
    pin = 1'b1;
    wr(8'h01, 1, 16'h0080, 0);
    for (int i = 1; i <= SC + 2; i++) begin
      @(negedge i_sys_clk) sw = 1'b1;
      @(negedge i_sys_clk) sw = 1'b0;
      idle(4);
      if (i >= SC - 1) chkb("low side full", i >= SC, full);
    end
    check("ramp count", SC, {8'h00, ramp});
    $display("Test soft ramp done");
    wr(`PMAC_CMD_VENDOR21, 1, 16'h0000, 0);
    ara(q, a);
    chkb("alert nack when idle", 1'b1, a);
    @(negedge i_sys_clk) faults[0] = 1'b1;
    idle(6);
    faults[0] = 1'b0;
    idle(6);
    chkb("alert on fault", 1'b1, alert_oe);
    ara(v[7:0], a);
    chkb("alert ack", 1'b0, a);
    check("alert answer", {8'h00, addr, 1'b0}, {8'h00, v[7:0]});
    chkb("standard alert held", 1'b1, alert_oe);
    wr(8'h03, 0, 16'h0000, 0);
    chkb("alert released", 1'b0, alert_oe);
    rd(`PMAC_CMD_STATUS, 1, v);
    check("status cleared", 16'h0000, v);
    faults[2] = 1'b1;
    idle(8);
    wr(8'h03, 0, 16'h0000, 0);
    chkb("persistent alert", 1'b1, alert_oe);
    wr(8'h1b, 1, 16'h000c, 0);
    wr(8'h03, 0, 16'h0000, 0);
    chkb("masked alert", 1'b0, alert_oe);
    faults = 8'h00;
    wr(8'h1b, 1, 16'h0008, 0);
    wr(8'h03, 0, 16'h0000, 0);
    $display("Test standard alert done");
    wr(`PMAC_CMD_VENDOR21, 1, 16'h0001, 0);
    @(negedge i_sys_clk) faults[0] = 1'b1;
    idle(8);
    ara(v[7:0], a);
    chkb("auto release", 1'b0, alert_oe);
    idle(30);
    chkb("stays released", 1'b0, alert_oe);
    faults[4] = 1'b1;
    idle(8);
    chkb("new fault alerts", 1'b1, alert_oe);
    faults = 8'h00;
    wr(8'h03, 0, 16'h0000, 0);
    $display("Test auto release done");
    wr(8'h21, 2, 16'h0155, 1);
    check("pec write", 16'h0155, setpoint);
    wr(8'h21, 2, 16'h0177, 2);
    check("bad pec dropped", 16'h0155, setpoint);
    for (int k = 0; k < 2; k++) begin
      sv = 16'($urandom);
      wr(8'h21, 2, sv, 0);
      wr(k ? 8'h15 : 8'h11, 0, 16'h0000, 0);
      wr(8'h21, 2, ~sv, 0);
      wr(k ? 8'h16 : 8'h12, 0, 16'h0000, 0);
      check("restored setpoint", sv, setpoint);
    end
    wr(8'h10, 1, 16'h0020, 0);
    wr(8'h21, 2, ~sv, 0);
    check("locked setpoint", sv, setpoint);
    wr(8'h10, 1, 16'h0000, 0);
    wr(8'h03, 0, 16'h0000, 0);
    $display("Test store and lock done");
    @(negedge i_sys_clk) st_hi = 4'h9;
    idle(8);
    addr = `PMAC_ADDR_BAD;
    rd(8'h19, 1, v);
    check("strap fallback read", 16'h00b0, v);
    $display("Test address fallback done");
    give_verdict();
  end
endmodule
